//--- rate_sel_pkg.sv
package rate_sel_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int FIELD_W = 4;

  // register offsets
  localparam logic [ADDR_W-1:0] NOISE_SOURCE_RATE_ADDR      = 16'h00A0;
  localparam logic [ADDR_W-1:0] INPUT_PATHS_RATE_ADDR       = 16'h0308;
  localparam logic [ADDR_W-1:0] OUTPUT_PATHS_RATE_ADDR      = 16'h0408;
  localparam logic [ADDR_W-1:0] SERIAL_PORT_ONE_RATE_ADDR   = 16'h0503;
  localparam logic [ADDR_W-1:0] SERIAL_PORT_TWO_RATE_ADDR   = 16'h0543;
  localparam logic [ADDR_W-1:0] SERIAL_PORT_THREE_RATE_ADDR = 16'h0583;
  localparam logic [ADDR_W-1:0] DIGITAL_TX_RATE_ADDR        = 16'h05C2;
  localparam logic [ADDR_W-1:0] BUS_CHANNEL_RATES_FIRST_ADDR = 16'h05E5;

  // field positions (low bit of each 4-bit field)
  localparam int HIGH_FIELD_LSB = 11;
  localparam int LOW_FIELD_LSB  = 4;

  // field codes
  localparam logic [FIELD_W-1:0] RATE_ONE   = 4'h0;
  localparam logic [FIELD_W-1:0] RATE_TWO   = 4'h1;
  localparam logic [FIELD_W-1:0] RATE_THREE = 4'h2;
  localparam logic [FIELD_W-1:0] FIELD_RESET = RATE_ONE;

  localparam int NUM_FIELDS = 8;

  // decoded one-hot choice of global rate
  typedef struct packed {
    logic three;
    logic two;
    logic one;
  } rate_pick_s;

  // register port request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

endpackage : rate_sel_pkg

//--- rate_field.sv
`timescale 1ns/100ps
`default_nettype none
module rate_field
  import rate_sel_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               nrst,
  input  wire logic               wr_en,
  input  wire logic [FIELD_W-1:0] wr_code,
  output var  logic [FIELD_W-1:0] code,
  output var  rate_pick_s         pick
);

  logic [FIELD_W-1:0] next_code;
  rate_pick_s         next_pick;

  // reserved codes are stored as written; the pick then selects no rate
  always_comb begin
    next_code       = wr_en ? wr_code : code;
    next_pick.one   = (next_code == RATE_ONE);
    next_pick.two   = (next_code == RATE_TWO);
    next_pick.three = (next_code == RATE_THREE);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      code <= FIELD_RESET;
      pick <= '{one: 1'b1, default: 1'b0}; // reset code picks rate one
    end else begin
      code <= next_code;
      pick <= next_pick;
    end
  end

endmodule : rate_field
`default_nettype wire

//--- core_sample_rate_select.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - noise generator rate field, bits 14:11, codes pick rate one, two or three.
// - one input-path rate field at bits 14:11 shared by all inputs.
// - output-path rate field at bits 14:11 for all outputs.
// - three serial port rate fields at bits 14:11 of three registers.
// - digital transmitter rate field at bits 7:4.
// - at most three rates, all synchronous to the audio clock, each field picks one, or none for a reserved code.
module core_sample_rate_select
  import rate_sel_pkg::*;
(
  input  wire logic                       mclk,
  input  wire logic                       nrst,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [ADDR_W-1:0]          reg_addr,
  input  wire logic [DATA_W-1:0]          reg_wdata,
  output var  logic [DATA_W-1:0]          reg_rdata,
  output var  logic [NUM_FIELDS-1:0]      rate_one_sel,
  output var  logic [NUM_FIELDS-1:0]      rate_two_sel,
  output var  logic [NUM_FIELDS-1:0]      rate_three_sel
);

  // field index order
  localparam int F_NOISE = 0;
  localparam int F_IN    = 1;
  localparam int F_OUT   = 2;
  localparam int F_SP1   = 3;
  localparam int F_SP2   = 4;
  localparam int F_SP3   = 5;
  localparam int F_DTX   = 6;
  localparam int F_BUSRX = 7;

  reg_req_s req;
  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  logic [NUM_FIELDS-1:0]  hit;
  logic [FIELD_W-1:0]     wr_code [NUM_FIELDS];
  logic [FIELD_W-1:0]     code    [NUM_FIELDS];
  rate_pick_s             pick    [NUM_FIELDS];
  logic [DATA_W-1:0]      next_rdata;

  // address decode; the bus channel register holds the first receive channel
  always_comb begin
    hit          = '0;
    hit[F_NOISE] = (req.addr == NOISE_SOURCE_RATE_ADDR);
    hit[F_IN]    = (req.addr == INPUT_PATHS_RATE_ADDR);
    hit[F_OUT]   = (req.addr == OUTPUT_PATHS_RATE_ADDR);
    hit[F_SP1]   = (req.addr == SERIAL_PORT_ONE_RATE_ADDR);
    hit[F_SP2]   = (req.addr == SERIAL_PORT_TWO_RATE_ADDR);
    hit[F_SP3]   = (req.addr == SERIAL_PORT_THREE_RATE_ADDR);
    hit[F_DTX]   = (req.addr == DIGITAL_TX_RATE_ADDR);
    hit[F_BUSRX] = (req.addr == BUS_CHANNEL_RATES_FIRST_ADDR);
  end

  // the transmitter field sits low; every other field sits at 14:11
  always_comb begin
    for (int i = 0; i < NUM_FIELDS; i++) begin
      wr_code[i] = req.wdata[HIGH_FIELD_LSB +: FIELD_W];
    end
    wr_code[F_DTX] = req.wdata[LOW_FIELD_LSB +: FIELD_W];
  end

  // one storage cell per field; range limits are software's duty, not checked
  genvar g;
  generate
    for (g = 0; g < NUM_FIELDS; g++) begin : g_field
      rate_field u_field (
        .mclk    (mclk),
        .nrst    (nrst),
        .wr_en   (req.wr && hit[g]),
        .wr_code (wr_code[g]),
        .code    (code[g]),
        .pick    (pick[g])
      );
    end
  endgenerate

  // read mux; unmapped addresses and undocumented bits read zero
  always_comb begin
    next_rdata = '0;
    if (req.rd) begin
      for (int i = 0; i < NUM_FIELDS; i++) begin
        if (hit[i] && i != F_DTX) begin
          next_rdata[HIGH_FIELD_LSB +: FIELD_W] = code[i];
        end
      end
      if (hit[F_DTX]) begin
        next_rdata[LOW_FIELD_LSB +: FIELD_W] = code[F_DTX];
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // one-hot selects come straight from the field cells' flops
  always_comb begin
    for (int i = 0; i < NUM_FIELDS; i++) begin
      rate_one_sel[i]   = pick[i].one;
      rate_two_sel[i]   = pick[i].two;
      rate_three_sel[i] = pick[i].three;
    end
  end

endmodule : core_sample_rate_select
`default_nettype wire

//--- core_sample_rate_select_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module core_sample_rate_select_assertions
  import rate_sel_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  nrst,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [ADDR_W-1:0]     reg_addr,
  input wire logic [DATA_W-1:0]     reg_wdata,
  input wire logic [DATA_W-1:0]     reg_rdata,
  input wire logic [NUM_FIELDS-1:0] rate_one_sel,
  input wire logic [NUM_FIELDS-1:0] rate_two_sel,
  input wire logic [NUM_FIELDS-1:0] rate_three_sel
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // reserved codes must pick no rate at all
  function automatic logic [2:0] pk(logic [15:0] d, int l);
    return {d[l+:4] == 4'h2, d[l+:4] == 4'h1, d[l+:4] == 4'h0};
  endfunction : pk
  // a write lands on the pick outputs one cycle later
  property p_fld(logic [15:0] a, int i, int l);
    reg_wr && reg_addr == a |=>
      {rate_three_sel[i], rate_two_sel[i], rate_one_sel[i]} == pk($past(reg_wdata), l);
  endproperty
  property p_noise; p_fld(16'h00A0, 0, 11); endproperty
  property p_inp; p_fld(16'h0308, 1, 11); endproperty
  property p_out; p_fld(16'h0408, 2, 11); endproperty
  property p_port; p_fld(16'h0583, 5, 11); endproperty
  property p_port1; p_fld(16'h0503, 3, 11); endproperty
  property p_port2; p_fld(16'h0543, 4, 11); endproperty
  property p_tx; p_fld(16'h05C2, 6, 4); endproperty
  property p_excl;
    (rate_one_sel & rate_two_sel | rate_three_sel & (rate_one_sel | rate_two_sel)) == 8'h00;
  endproperty
  property p_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
  property p_mask; reg_rd && reg_addr != 16'h05C2 |=> (reg_rdata & 16'h87FF) == 16'h0000;
  endproperty
  a_noise: assert property (p_noise) else $error("noise pick wrong");
  a_inp: assert property (p_inp) else $error("input pick wrong");
  a_out: assert property (p_out) else $error("output pick wrong");
  a_port: assert property (p_port) else $error("port pick wrong");
  a_port1: assert property (p_port1) else $error("port one pick wrong");
  a_port2: assert property (p_port2) else $error("port two pick wrong");
  a_tx: assert property (p_tx) else $error("tx pick wrong");
  a_excl: assert property (p_excl) else $error("two rates picked");
  a_idle: assert property (p_idle) else $error("rdata not zero");
  a_mask: assert property (p_mask) else $error("loose bits set");
endmodule : core_sample_rate_select_assertions
bind core_sample_rate_select core_sample_rate_select_assertions chk (.mclk(mclk), .nrst(nrst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .rate_one_sel(rate_one_sel), .rate_two_sel(rate_two_sel),
  .rate_three_sel(rate_three_sel));
`default_nettype wire

//--- core_sample_rate_select_tb.sv
`timescale 1ns/100ps
`default_nettype none
module core_sample_rate_select_tb
  import rate_sel_pkg::*;
;
  logic        mclk, nrst, reg_wr, reg_rd;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, d, a;
  logic [31:0] seed;
  logic [7:0]  s1, s2, s3;
  logic [3:0]  code [8];
  int          fails, n_compared, j;
  localparam logic [15:0] AD [8] = '{16'h00A0, 16'h0308, 16'h0408, 16'h0503,
                                     16'h0543, 16'h0583, 16'h05C2, 16'h05E5};
  core_sample_rate_select dut (.mclk(mclk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rate_one_sel(s1), .rate_two_sel(s2), .rate_three_sel(s3));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [2:0] pk(logic [3:0] c);
    return {c == 4'h2, c == 4'h1, c == 4'h0};
  endfunction : pk
  // the tx field alone sits low in its word
  function automatic logic [15:0] ex(int i);
    return i == 6 ? {8'h00, code[6], 4'h0} : {1'b0, code[i], 11'h000};
  endfunction : ex
  task automatic chk(string nm, logic [15:0] got, logic [15:0] want);
    n_compared++;
    if (got !== want) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, want, got);
    end
  endtask : chk
  task automatic wr(logic [15:0] ad, logic [15:0] dv);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= dv;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // rdata stands only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(int i, logic [15:0] ad, logic [15:0] want);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk("rdata", reg_rdata, want);
    chk("pick", {13'h0000, s3[i], s2[i], s1[i]}, {13'h0000, pk(code[i])});
    @(posedge mclk);
  endtask : rd
  task automatic summarize();
    if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // random field writes, some to the unmapped word just above, each read straight back
  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    fails = 0;
    n_compared = 0;
    seed = 32'hF050EF73;
    foreach (code[k]) code[k] = 4'h0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    for (int k = 0; k < 8; k++) rd(k, AD[k], 16'h0000);
    repeat (300) begin
      seed = lfsr(seed);
      j = int'(seed[2:0]);
      d = seed[31:16];
      // only the three defined codes; no sources or Hz rates exist here to break the duties
      if (j == 6) d[7:4] = {2'b00, seed[5], seed[4] & ~seed[5]};
      else d[14:11] = {2'b00, seed[5], seed[4] & ~seed[5]};
      a = AD[j] + {15'h0000, seed[8]};
      wr(a, d);
      if (!seed[8]) code[j] = j == 6 ? d[7:4] : d[14:11];
      rd(j, a, seed[8] ? 16'h0000 : ex(j));
    end
    summarize();
  end
  // about 920 cycles are needed; cut off well past that
  initial begin
    #100000;
    fails++;
    summarize();
  end
endmodule : core_sample_rate_select_tb
`default_nettype wire
